//--- dbw_pkg.sv
/*
 Package for the double-rate SRAM byte-write mask block: widths, lane layout,
 width options and write sequencer states.
 Assumes a single 20 MHz clock; no imports are used anywhere.
*/
package dbw_pkg;
   localparam int LANE_W = 9;
   localparam int MAX_LANES = 4;
   localparam int DATA_W = 36;
   localparam int ADDR_W = 8;
   localparam int DEPTH = 256;
   localparam logic [DATA_W-1:0] RESET_WORD = 36'h000000000;
   localparam logic [MAX_LANES-1:0] SEL_IDLE = 4'hF;
   localparam logic [ADDR_W-1:0] ADDR_STEP = 8'h01;

   typedef enum logic [1:0] {
      DBW_W9 = 2'h0,
      DBW_W18 = 2'h1,
      DBW_W36 = 2'h2
   } dbw_width_t;

   // Gray order along the usual path: idle -> address -> first beat -> second beat
   typedef enum logic [1:0] {
      DBW_IDLE = 2'h0,
      DBW_ADDR = 2'h1,
      DBW_BEAT0 = 2'h3,
      DBW_BEAT1 = 2'h2
   } dbw_state_t;
endpackage : dbw_pkg

//--- dbw_lane_mask.sv
/*
 One 9-bit lane of the write merge: keeps the stored lane unless its
 active-low select was low for the beat.
 Assumes the caller has already resolved which select governs this lane.
*/
`timescale 1ns/1ps
module dbw_lane_mask (
   // Lane data
   input wire logic [dbw_pkg::LANE_W-1:0] old_lane,
   input wire logic [dbw_pkg::LANE_W-1:0] new_lane,
   // Active-low lane select
   input wire logic lane_select_n,
   // Merged result
   output logic [dbw_pkg::LANE_W-1:0] merged_lane
);
   assign merged_lane = lane_select_n ? old_lane : new_lane; // R3
endmodule : dbw_lane_mask

//--- dbw_write_port.sv
/*
 Write port of a double-data-rate SRAM with byte-lane masking.
 The true and complement input clock rises arrive as one-cycle enables
 (k_rise, kn_rise) from logic on clk. Pins other than the width strap pass two flops first.
 Width option is a strap caught once after reset release.
*/
// Summary of operation
// R1: In 18-bit mode both selects low writes all 18 bits of the beat.
// R2: In 18-bit mode select 0 alone writes bits 8:0 and select 1 alone writes bits 17:9.
// R3: In 18-bit mode both selects high leaves the word unchanged for that beat.
// R4: In 9-bit mode the single select low stores bits 8:0 for the beat.
// R5: In 9-bit and 36-bit modes all selects high writes nothing for the beat.
// R6: In 36-bit mode all four selects low writes the full 36-bit word.
// R7: In 36-bit mode each select enables only its own 9-bit lane.
// R8: Each beat of a burst uses its own selects, which may differ between beats.
// R9: After power-up both ports are deselected and read outputs are high impedance.
// R10: The first beat goes to latched address A and the second to A plus one.
// R11: Write data is registered on both input clock rises; read data launches on output rises (the code launches it on the true input rise, s_k).
// R12: A stopped clock should be held high on all phases for fastest restart.
// R13: A write starts with the port select low at a true rise; address is latched at the next complement rise.
// R14: Selects are sampled with each data word, once per clock phase.
// R15: When deselected the port finishes any pending write and then ignores its inputs.
`timescale 1ns/1ps
module dbw_write_port (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Clock phase enables from the input clock pins
   input wire logic k_rise,
   input wire logic kn_rise,
   // Width strap
   input wire logic [1:0] width_strap,
   // Write port pins
   input wire logic write_port_select_n,
   input wire logic [dbw_pkg::ADDR_W-1:0] addr,
   input wire logic [dbw_pkg::DATA_W-1:0] write_data,
   input wire logic [dbw_pkg::MAX_LANES-1:0] byte_lane_select_n,
   // Read port, word at read_addr launched on a true rise
   input wire logic read_port_select_n,
   input wire logic [dbw_pkg::ADDR_W-1:0] read_addr,
   output logic [dbw_pkg::DATA_W-1:0] read_data,
   output logic read_data_oe_n,
   // Status
   output logic write_busy,
   output logic write_commit
);
   ////////////////////////////////////////////////////////////////////////
   logic rst_meta_n;
   logic rst_sync_n;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_meta_n <= 1'b0;
         rst_sync_n <= 1'b0;
      end else begin
         rst_meta_n <= 1'b1;
         rst_sync_n <= rst_meta_n;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Two-flop synchronisers on every pin input except the width strap
   localparam int IN_W = 4 + 2 * dbw_pkg::ADDR_W + dbw_pkg::DATA_W + dbw_pkg::MAX_LANES;
   // Idle pin picture: no phase pulse, both ports deselected, no lane selected
   localparam logic [IN_W-1:0] PIN_IDLE = {2'h0, 1'h1, {dbw_pkg::ADDR_W{1'b0}},
      dbw_pkg::RESET_WORD, dbw_pkg::SEL_IDLE, 1'h1, {dbw_pkg::ADDR_W{1'b0}}};
   logic [IN_W-1:0] pin_meta;
   logic [IN_W-1:0] pin_sync;
   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         pin_meta <= PIN_IDLE; // R9
         pin_sync <= PIN_IDLE; // R9
      end else begin
         pin_meta <= {k_rise, kn_rise, write_port_select_n, addr, write_data,
                      byte_lane_select_n, read_port_select_n, read_addr};
         pin_sync <= pin_meta;
      end
   end
   logic s_k;
   logic s_kn;
   logic s_wsel_n;
   logic [dbw_pkg::ADDR_W-1:0] s_addr;
   logic [dbw_pkg::DATA_W-1:0] s_data;
   logic [dbw_pkg::MAX_LANES-1:0] s_sel_n;
   logic s_rsel_n;
   logic [dbw_pkg::ADDR_W-1:0] s_raddr;
   assign {s_k, s_kn, s_wsel_n, s_addr, s_data, s_sel_n, s_rsel_n, s_raddr} = pin_sync;

   // Width strap caught once after release
   dbw_pkg::dbw_width_t width_mode;
   logic strap_taken;
   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         width_mode <= dbw_pkg::DBW_W18;
         strap_taken <= 1'b0;
      end else if (!strap_taken) begin
         strap_taken <= 1'b1;
         case (width_strap)
            2'h0: width_mode <= dbw_pkg::DBW_W9;
            2'h2: width_mode <= dbw_pkg::DBW_W36;
            default: width_mode <= dbw_pkg::DBW_W18;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Write sequencer
   dbw_pkg::dbw_state_t state;
   logic [dbw_pkg::ADDR_W-1:0] burst_addr;
   logic [dbw_pkg::DATA_W-1:0] beat0_data;
   logic [dbw_pkg::MAX_LANES-1:0] beat0_sel_n;
   logic [dbw_pkg::DATA_W-1:0] beat1_data;
   logic [dbw_pkg::MAX_LANES-1:0] beat1_sel_n;
   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         state <= dbw_pkg::DBW_IDLE; // R9
         burst_addr <= '0;
         beat0_data <= dbw_pkg::RESET_WORD;
         beat0_sel_n <= dbw_pkg::SEL_IDLE;
         beat1_data <= dbw_pkg::RESET_WORD;
         beat1_sel_n <= dbw_pkg::SEL_IDLE;
      end else begin
         case (state)
            dbw_pkg::DBW_IDLE: begin
               if (s_k && !s_wsel_n) begin // R13 R15
                  beat0_data <= s_data; // R11
                  beat0_sel_n <= s_sel_n; // R14
                  state <= dbw_pkg::DBW_ADDR;
               end
            end
            dbw_pkg::DBW_ADDR: begin
               if (s_kn) begin
                  burst_addr <= s_addr; // R13
                  beat1_data <= s_data; // R11
                  beat1_sel_n <= s_sel_n; // R14 R8
                  state <= dbw_pkg::DBW_BEAT0;
               end
            end
            dbw_pkg::DBW_BEAT0: begin
               // Step as the first beat is stored so the second lands at A plus one
               burst_addr <= burst_addr + dbw_pkg::ADDR_STEP; // R10
               state <= dbw_pkg::DBW_BEAT1;
            end
            default: begin
               state <= dbw_pkg::DBW_IDLE; // R15
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Lane select resolution and merge
   logic beat_second;
   logic [dbw_pkg::DATA_W-1:0] cur_data;
   logic [dbw_pkg::MAX_LANES-1:0] cur_sel_n;
   logic [dbw_pkg::MAX_LANES-1:0] lane_sel_n;
   logic [dbw_pkg::DATA_W-1:0] old_word;
   logic [dbw_pkg::DATA_W-1:0] merged_word;
   logic [dbw_pkg::DATA_W-1:0] mem [dbw_pkg::DEPTH];

   assign beat_second = (state == dbw_pkg::DBW_BEAT1);
   assign cur_data = beat_second ? beat1_data : beat0_data; // R8
   assign cur_sel_n = beat_second ? beat1_sel_n : beat0_sel_n; // R8
   assign old_word = mem[burst_addr];

   always_comb begin
      case (width_mode)
         dbw_pkg::DBW_W9: lane_sel_n = {3'h7, cur_sel_n[0]}; // R4 R5
         dbw_pkg::DBW_W18: lane_sel_n = {2'h3, cur_sel_n[1:0]}; // R1 R2 R3
         default: lane_sel_n = cur_sel_n; // R6 R7 R5
      endcase
   end

   genvar gl;
   generate
      for (gl = 0; gl < dbw_pkg::MAX_LANES; gl++) begin : g_lane
         dbw_lane_mask u_lane (
            .old_lane(old_word[gl*dbw_pkg::LANE_W +: dbw_pkg::LANE_W]),
            .new_lane(cur_data[gl*dbw_pkg::LANE_W +: dbw_pkg::LANE_W]),
            .lane_select_n(lane_sel_n[gl]),
            .merged_lane(merged_word[gl*dbw_pkg::LANE_W +: dbw_pkg::LANE_W])
         ); // R7
      end
   endgenerate

   logic array_write;
   assign array_write = (state == dbw_pkg::DBW_BEAT0) || beat_second;
   always_ff @(posedge clk) begin
      if (array_write) begin
         mem[burst_addr] <= merged_word; // R1 R2 R3 R6
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read launch and status outputs
   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         read_data <= dbw_pkg::RESET_WORD;
         read_data_oe_n <= 1'b1; // R9
      end else if (s_k) begin
         read_data_oe_n <= s_rsel_n; // R11
         read_data <= mem[s_raddr]; // R11
      end
   end

   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         write_busy <= 1'b0;
         write_commit <= 1'b0;
      end else begin
         write_busy <= (state != dbw_pkg::DBW_IDLE);
         write_commit <= beat_second;
      end
   end
endmodule : dbw_write_port

//--- dbw_ctrl_model.sv
/*
 Memory controller model driving the write and read pins of the port.
 Assumes one clk; pins change on falling edges, phase pulses one clk wide.
*/
`timescale 1ns/1ps
module dbw_ctrl_model (
   // Clock
   input wire logic clk,
   // Clock phase pulses
   output logic k_rise,
   output logic kn_rise,
   // Write port
   output logic write_port_select_n,
   output logic [dbw_pkg::ADDR_W-1:0] addr,
   output logic [dbw_pkg::DATA_W-1:0] write_data,
   output logic [dbw_pkg::MAX_LANES-1:0] byte_lane_select_n,
   // Read port
   output logic read_port_select_n,
   output logic [dbw_pkg::ADDR_W-1:0] read_addr
);
   initial begin
      k_rise = 1'b0;
      kn_rise = 1'b0;
      write_port_select_n = 1'b1;
      read_port_select_n = 1'b1;
      addr = 8'h00;
      read_addr = 8'h00;
      write_data = 36'h000000000;
      byte_lane_select_n = dbw_pkg::SEL_IDLE;
   end
   // Pins stay put three cycles on each side of a phase pulse
   task automatic pulse(input logic second);
      repeat (3) @(negedge clk);
      k_rise = ~second;
      kn_rise = second;
      @(negedge clk);
      k_rise = 1'b0;
      kn_rise = 1'b0;
      repeat (3) @(negedge clk);
   endtask : pulse
   task automatic wr(input logic [7:0] a, input logic [35:0] d0, input logic [3:0] s0,
                     input logic [35:0] d1, input logic [3:0] s1);
      write_port_select_n = 1'b0;
      write_data = d0;
      byte_lane_select_n = s0;
      pulse(1'b0);
      write_port_select_n = 1'b1;
      addr = a;
      write_data = d1;
      byte_lane_select_n = s1;
      pulse(1'b1);
      // Released lines carry inverted junk, not the last value
      addr = ~a;
      write_data = ~d1;
      byte_lane_select_n = ~s1;
      repeat (4) @(negedge clk);
   endtask : wr
   task automatic rd(input logic [7:0] a);
      read_port_select_n = 1'b0;
      read_addr = a;
      pulse(1'b0);
      read_port_select_n = 1'b1;
      read_addr = ~a;
   endtask : rd
endmodule : dbw_ctrl_model

//--- dbw_write_port_chk.sv
/*
 Assertions on write status and read data timing of the write port.
 Bound into every dbw_write_port; sees its ports only.
*/
`timescale 1ns/1ps
module dbw_write_port_chk (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Watched inputs
   input wire logic k_rise,
   input wire logic kn_rise,
   input wire logic write_port_select_n,
   // Watched outputs
   input wire logic [dbw_pkg::DATA_W-1:0] read_data,
   input wire logic write_busy,
   input wire logic write_commit
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   sequence s_beat1; kn_rise && write_busy; endsequence
   sequence s_done; ##[4:6] write_commit; endsequence
   property p_commit_after_beat; s_beat1 |-> s_done; endproperty
   property p_commit_pulse; write_commit |=> !write_commit; endproperty
   property p_commit_in_burst; write_commit |-> $past(write_busy); endproperty
   property p_busy_ends; $fell(write_busy) |-> $past(write_commit); endproperty
   property p_commit_idle; write_commit |-> write_busy; endproperty
   property p_busy_start; $rose(write_busy) |-> $past(k_rise, 4); endproperty
   property p_desel;
      k_rise && write_port_select_n |-> ##3 !$rose(write_busy) ##1 !$rose(write_busy);
   endproperty
   property p_read_launch;
      $changed(read_data) |-> $past(k_rise, 2) || $past(k_rise, 3);
   endproperty
   a_commit_after_beat: assert property (p_commit_after_beat) else $error("no commit");
   a_commit_pulse: assert property (p_commit_pulse) else $error("long commit");
   a_commit_in_burst: assert property (p_commit_in_burst) else $error("stray commit");
   a_busy_ends: assert property (p_busy_ends) else $error("burst lost");
   a_commit_idle: assert property (p_commit_idle) else $error("idle at commit");
   a_busy_start: assert property (p_busy_start) else $error("burst without k");
   a_desel: assert property (p_desel) else $error("deselected burst");
   a_read_launch: assert property (p_read_launch) else $error("read data moved");
endmodule : dbw_write_port_chk
bind dbw_write_port dbw_write_port_chk i_dbw_write_port_chk (.clk(clk), .rst_n(rst_n),
   .k_rise(k_rise), .kn_rise(kn_rise), .write_port_select_n(write_port_select_n),
   .read_data(read_data), .write_busy(write_busy), .write_commit(write_commit));

//--- dbw_write_port_tb.sv
/*
 Self-checking bench for the write port in the 9, 18 and 36-bit options.
 Pins come from dbw_ctrl_model; the checker is bound in.
*/
`timescale 1ns/1ps
module dbw_write_port_tb;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [1:0] width_strap = 2'h1;
   logic k_rise, kn_rise, write_port_select_n, read_port_select_n;
   logic [dbw_pkg::ADDR_W-1:0] addr, read_addr;
   logic [dbw_pkg::DATA_W-1:0] write_data, read_data;
   logic [dbw_pkg::DATA_W-1:0] exp [dbw_pkg::DEPTH];
   logic [dbw_pkg::MAX_LANES-1:0] byte_lane_select_n;
   logic read_data_oe_n, write_busy, write_commit;
   int n_mismatch = 0;
   int cmp_count = 0;
   int cyc = 0;
   int nl = 2;
   dbw_write_port i_dbw_write_port (.clk(clk), .rst_n(rst_n), .k_rise(k_rise),
      .kn_rise(kn_rise), .width_strap(width_strap), .write_port_select_n(write_port_select_n),
      .addr(addr), .write_data(write_data), .byte_lane_select_n(byte_lane_select_n),
      .read_port_select_n(read_port_select_n), .read_addr(read_addr), .read_data(read_data),
      .read_data_oe_n(read_data_oe_n), .write_busy(write_busy), .write_commit(write_commit));
   dbw_ctrl_model i_dbw_ctrl_model (.clk(clk), .k_rise(k_rise), .kn_rise(kn_rise),
      .write_port_select_n(write_port_select_n), .addr(addr), .write_data(write_data),
      .byte_lane_select_n(byte_lane_select_n), .read_port_select_n(read_port_select_n),
      .read_addr(read_addr));
   initial forever #25 clk = ~clk;
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         n_mismatch++;
         end_of_test();
      end
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic end_of_test();
      if (n_mismatch == 0 && cmp_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : end_of_test
   task automatic cmp_data(input logic [35:0] got, input logic [35:0] want);
      cmp_count++;
      if (got !== want) begin
         n_mismatch++;
         $display("BAD %0t data %h want %h", $time, got, want);
      end
   endtask : cmp_data
   task automatic cmp_flag(input logic got, input logic want);
      cmp_count++;
      if (got !== want) begin
         n_mismatch++;
         $display("BAD %0t flag %b want %b", $time, got, want);
      end
   endtask : cmp_flag
   task automatic do_reset(input logic [1:0] strap, input int lanes);
      @(negedge clk);
      rst_n = 1'b0;
      width_strap = strap;
      nl = lanes;
      repeat (10) @(negedge clk);
      rst_n = 1'b1;
      repeat (4) @(negedge clk);
      cmp_flag(read_data_oe_n, 1'b1);
      cmp_data(read_data, dbw_pkg::RESET_WORD);
   endtask : do_reset
   // Expected array: only lanes of the option whose select is low change
   task automatic merge(input logic [7:0] a, input logic [35:0] d, input logic [3:0] s);
      for (int n = 0; n < nl; n++) if (!s[n]) exp[a][9*n +: 9] = d[9*n +: 9];
   endtask : merge
   task automatic wr(input logic [7:0] a, input logic [35:0] d0, input logic [3:0] s0,
                     input logic [35:0] d1, input logic [3:0] s1);
      i_dbw_ctrl_model.wr(a, d0, s0, d1, s1);
      merge(a, d0, s0);
      merge(a + 8'h01, d1, s1);
   endtask : wr
   task automatic chk(input logic [7:0] a);
      logic [35:0] m;
      m = (36'h000000001 << (9 * nl)) - 36'h000000001;
      i_dbw_ctrl_model.rd(a);
      cmp_flag(read_data_oe_n, 1'b0);
      cmp_data(read_data & m, exp[a] & m);
   endtask : chk
   task automatic t_w18();
      do_reset(2'h1, 2);
      wr(8'h10, 36'h2468ACE13, 4'h0, 36'h13579BDF0, 4'h0);
      wr(8'h10, 36'h0000155AA, 4'hE, 36'h00002A955, 4'hD);
      wr(8'h10, 36'h00003FFFF, 4'hF, 36'h000012345, 4'hC);
      chk(8'h10);
      chk(8'h11);
   endtask : t_w18
   task automatic t_w9();
      do_reset(2'h0, 1);
      wr(8'hFF, 36'h0000001A5, 4'h0, 36'h00000005A, 4'h0);
      wr(8'hFF, 36'h0000001FF, 4'hF, 36'h000000133, 4'hE);
      chk(8'hFF);
      chk(8'h00);
   endtask : t_w9
   task automatic t_w36();
      do_reset(2'h2, 4);
      wr(8'h20, 36'h0F0F0F0F0, 4'h0, 36'h987654321, 4'h0);
      for (int n = 0; n < 4; n++) wr(8'h20, {4{9'(n + 1)}}, ~(4'h1 << n), 36'h0, 4'hF);
      chk(8'h20);
      chk(8'h21);
   endtask : t_w36
   initial begin
      t_w18();
      t_w9();
      t_w36();
      end_of_test();
   end
endmodule : dbw_write_port_tb
